// *** rtl/nvpot_pkg.sv ***
package nvpot_pkg;
    // 7-bit bus address; 50h on the wire for writes, 51h for reads
    localparam logic [6:0] DEV_ADDR = 7'h28;
    localparam logic [7:0] WIPER_LOC = 8'h00;
    localparam int CTRL_WIPER_ONLY_BIT = 7;
    localparam logic [7:0] ADDR_CNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_FREQ_HZ = 20000000;
    // nonvolatile write time in microseconds; plain default, adjust per process
    localparam int NV_WRITE_TIME_US = 10000;
    localparam int NV_WRITE_CYCLES_DEF = (NV_WRITE_TIME_US * (CLK_FREQ_HZ / 1000000));
    localparam int NV_CNT_W = 24;
    localparam logic [NV_CNT_W-1:0] NV_CNT_RESET = 24'h000000;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RX = 6'b000010,
        ST_ACK = 6'b000100,
        ST_TX = 6'b001000,
        ST_MACK = 6'b010000,
        ST_IGNORE = 6'b100000
    } port_state_t;

    typedef enum logic [2:0] {
        PH_DEVADDR = 3'b001,
        PH_MEMLOC = 3'b010,
        PH_DATA = 3'b100
    } phase_t;
endpackage : nvpot_pkg

// *** rtl/stream_if.sv ***
`timescale 1ns/10ps
interface stream_if #(
    parameter int WIDTH = 16
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// *** rtl/sync2.sv ***
`timescale 1ns/10ps
module sync2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // pins idle high, so reset to the released level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sync2

// *** rtl/byte_fifo.sv ***
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_s.ready = (count_q != (AW+1)'(DEPTH));
    assign out_s.valid = (count_q != '0);
    assign out_s.data = mem[rd_ptr_q];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule : byte_fifo

// *** rtl/i2c_slave_nv_pot_port.sv ***
`timescale 1ns/10ps
module i2c_slave_nv_pot_port #(
    parameter int unsigned NV_WRITE_CYCLES = nvpot_pkg::NV_WRITE_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wiper_only,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic nv_write_start,
    output logic [7:0] nv_write_addr,
    output logic [7:0] nv_write_data,
    output logic nv_busy
);
    import nvpot_pkg::*;

    logic scl_s;
    logic sda_s;
    logic scl_prev_q;
    logic sda_prev_q;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    port_state_t state_q;
    phase_t phase_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic [7:0] addr_cnt_q;
    logic read_q;
    logic ack_ok_q;
    logic sda_oe_q;
    logic nv_pend_q;
    logic [7:0] nv_addr_q;
    logic [7:0] nv_data_q;
    logic nv_start_q;
    logic nv_busy_q;
    logic [NV_CNT_W-1:0] nv_cnt_q;
    logic addr_match;
    logic byte_done;
    logic push;
    logic nv_commit;

    stream_if #(.WIDTH(FIFO_WIDTH)) push_s ();
    stream_if #(.WIDTH(FIFO_WIDTH)) pop_s ();

    sync2 u_sync_scl (
        .clk(mclk),
        .rst(rst),
        .d(scl_in),
        .q(scl_s)
    );

    sync2 u_sync_sda (
        .clk(mclk),
        .rst(rst),
        .d(sda_in),
        .q(sda_s)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;

    // busy device stays silent on its address so the master can poll
    assign addr_match = (rx_sh_q[7:1] == DEV_ADDR) & ~nv_busy_q;
    assign byte_done = scl_fall & (bit_cnt_q == BITS_PER_BYTE);

    // data byte is pushed as it is acked; a full buffer turns into a nack
    assign push = (state_q == ST_RX) & byte_done & (phase_q == PH_DATA) & push_s.ready;
    assign push_s.valid = push;
    assign push_s.data = {addr_cnt_q, rx_sh_q};

    byte_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst(rst),
        .in_s(push_s.snk),
        .out_s(pop_s.src)
    );

    assign wr_valid = pop_s.valid;
    assign pop_s.ready = wr_ready;
    assign wr_addr = pop_s.data[15:8];
    assign wr_data = pop_s.data[7:0];

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign rd_addr = addr_cnt_q;
    assign nv_write_start = nv_start_q;
    assign nv_write_addr = nv_addr_q;
    assign nv_write_data = nv_data_q;
    assign nv_busy = nv_busy_q;

    // byte level sequencing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            phase_q <= PH_DEVADDR;
            bit_cnt_q <= BIT_CNT_RESET;
            tx_sh_q <= BYTE_RESET;
            read_q <= 1'b0;
            ack_ok_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_RX;
            phase_q <= PH_DEVADDR;
            bit_cnt_q <= BIT_CNT_RESET;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= BIT_CNT_RESET;
                        if (phase_q == PH_DEVADDR) begin
                            if (addr_match) begin
                                state_q <= ST_ACK;
                                sda_oe_q <= 1'b1;
                                read_q <= rx_sh_q[0];
                                ack_ok_q <= 1'b1;
                            end else begin
                                state_q <= ST_IGNORE;
                            end
                        end else if (phase_q == PH_MEMLOC || push_s.ready) begin
                            state_q <= ST_ACK;
                            sda_oe_q <= 1'b1;
                            ack_ok_q <= 1'b1;
                            read_q <= 1'b0;
                        end else begin
                            state_q <= ST_ACK;
                            ack_ok_q <= 1'b0;
                            read_q <= 1'b0;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_ok_q) begin
                            sda_oe_q <= 1'b0;
                            state_q <= ST_IGNORE;
                        end else if (read_q) begin
                            tx_sh_q <= {rd_data[6:0], 1'b0};
                            sda_oe_q <= ~rd_data[7];
                            bit_cnt_q <= 4'h1;
                            state_q <= ST_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= ST_RX;
                            phase_q <= (phase_q == PH_DEVADDR) ? PH_MEMLOC : PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (byte_done) begin
                        sda_oe_q <= 1'b0;
                        bit_cnt_q <= BIT_CNT_RESET;
                        state_q <= ST_MACK;
                    end else if (scl_fall) begin
                        sda_oe_q <= ~tx_sh_q[7];
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        // master nack: release and wait for stop or start
                        ack_ok_q <= ~sda_s;
                    end else if (scl_fall) begin
                        if (ack_ok_q) begin
                            tx_sh_q <= {rd_data[6:0], 1'b0};
                            sda_oe_q <= ~rd_data[7];
                            bit_cnt_q <= 4'h1;
                            state_q <= ST_TX;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // receive shifter; a rise never coincides with a start or stop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_sh_q <= BYTE_RESET;
        end else if (state_q == ST_RX && scl_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], sda_s};
        end
    end

    // address counter: loaded by memory location, advanced per acked write byte and per read byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_cnt_q <= ADDR_CNT_RESET;
        end else if (state_q == ST_RX && byte_done && phase_q == PH_MEMLOC) begin
            addr_cnt_q <= rx_sh_q;
        end else if (push) begin
            addr_cnt_q <= addr_cnt_q + 8'h01;
        end else if (state_q == ST_MACK && scl_rise) begin
            addr_cnt_q <= addr_cnt_q + 8'h01;
        end
    end

    // pending nonvolatile write, committed only by a stop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nv_pend_q <= 1'b0;
            nv_addr_q <= BYTE_RESET;
            nv_data_q <= BYTE_RESET;
        end else if (start_det || stop_det) begin
            nv_pend_q <= 1'b0;
        end else if (push) begin
            // wiper-only mode keeps location 00h out of nonvolatile memory
            nv_pend_q <= ~(wiper_only & (addr_cnt_q == WIPER_LOC));
            nv_addr_q <= addr_cnt_q;
            nv_data_q <= rx_sh_q;
        end
    end

    // a stop during a busy cycle must not restart the timer
    assign nv_commit = stop_det & nv_pend_q & ~nv_busy_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nv_start_q <= 1'b0;
        end else begin
            nv_start_q <= nv_commit;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nv_busy_q <= 1'b0;
            nv_cnt_q <= NV_CNT_RESET;
        end else if (nv_commit) begin
            nv_busy_q <= 1'b1;
            nv_cnt_q <= NV_CNT_W'(NV_WRITE_CYCLES - 1);
        end else begin
            if (nv_busy_q) begin
                if (nv_cnt_q == NV_CNT_RESET) begin
                    nv_busy_q <= 1'b0;
                end else begin
                    nv_cnt_q <= nv_cnt_q - 1'b1;
                end
            end
        end
    end
endmodule : i2c_slave_nv_pot_port

// *** tb/nvpot_chk.sv ***
`timescale 1ns/10ps
module nvpot_chk #(
    parameter int unsigned NV_WRITE_CYCLES = nvpot_pkg::NV_WRITE_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wiper_only,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic nv_write_start,
    input wire logic [7:0] nv_write_addr,
    input wire logic nv_busy
);
    import nvpot_pkg::*;
    int unsigned busy_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_q <= 0;
        end else begin
            busy_q <= nv_busy ? busy_q + 1 : 0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence busy_run;
        nv_busy [*8];
    endsequence
    // scl fell a few cycles back, never on the same edge
    sequence after_fall;
        !scl_in && $past(scl_in, 6);
    endsequence
    AST_BUSY_START: assert property (nv_write_start |-> busy_run)
        else $error("busy missing after write start");
    AST_PULSE: assert property (nv_write_start |=> !nv_write_start)
        else $error("write start longer than one cycle");
    AST_BUSY_LEN: assert property ($fell(nv_busy) |-> busy_q == NV_WRITE_CYCLES)
        else $error("busy length wrong");
    AST_NO_ACK_BUSY: assert property (nv_busy |-> !$rose(sda_oe))
        else $error("drive while busy");
    AST_NO_RESTART: assert property (nv_busy && !$rose(nv_busy) |-> !nv_write_start)
        else $error("write restarted while busy");
    AST_DRIVE_FALL: assert property ($changed(sda_oe) |-> after_fall)
        else $error("sda drive changed off the scl fall");
    AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    AST_WR_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid
        && $stable({wr_addr, wr_data}))
        else $error("fifo head changed while stalled");
    AST_NV_STOP: assert property (nv_write_start |-> scl_in && sda_in)
        else $error("write start without stop");
    AST_WIPER: assert property (nv_write_start |-> !(wiper_only
        && nv_write_addr == WIPER_LOC))
        else $error("wiper-only write started");
endmodule : nvpot_chk
bind i2c_slave_nv_pot_port nvpot_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
    .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .wiper_only(wiper_only), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .nv_write_start(nv_write_start),
    .nv_write_addr(nv_write_addr), .nv_busy(nv_busy)
);

// *** tb/nvpot_master.sv ***
`timescale 1ns/10ps
module nvpot_master (
    input wire logic mclk,
    input wire logic sda_w,
    output logic scl,
    output logic sda_drv
);
    // 8 cycles per step; scl stays high one step and low two steps per bit, twice the floor the slave can resolve
    localparam int HP = 8;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hp();
        repeat (HP) @(posedge mclk);
    endtask : hp
    // also a repeated start when entered with scl low
    task automatic start();
        sda_drv <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_drv <= 1'b0;
        hp();
        scl <= 1'b0;
        hp();
    endtask : start
    task automatic stop();
        sda_drv <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_drv <= 1'b1;
        hp();
    endtask : stop
    // sda moves only in the low phase
    task automatic xbit(input logic b, output logic r);
        sda_drv <= b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda_w;
        scl <= 1'b0;
        hp();
    endtask : xbit
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(v[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            v[i] = r;
        end
        xbit(last, r);
    endtask : rbyte
endmodule : nvpot_master

// *** tb/i2c_slave_nv_pot_port_test.sv ***
`timescale 1ns/10ps
module i2c_slave_nv_pot_port_test;
    import nvpot_pkg::*;
    localparam int unsigned NVC = 400;
    logic mclk, rst, scl, sda_drv, sda_out, sda_oe, wiper_only, wr_valid, wr_ready;
    logic [7:0] rd_addr, rd_data, wr_addr, wr_data, nv_addr, nv_data, b;
    logic nv_start, nv_busy, ack;
    logic [15:0] nv_last;
    logic [15:0] popped[$];
    int err_count, comparisons, nv_cnt;
    // open drain with pull-up
    wire logic sda_w = sda_drv & (~sda_oe | sda_out);
    nvpot_master m (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_drv(sda_drv));
    i2c_slave_nv_pot_port #(.NV_WRITE_CYCLES(NVC)) uut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .wiper_only(wiper_only), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
        .nv_write_start(nv_start), .nv_write_addr(nv_addr), .nv_write_data(nv_data),
        .nv_busy(nv_busy)
    );
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (wr_valid === 1'b1 && wr_ready) begin
            popped.push_back({wr_addr, wr_data});
        end
        if (nv_start === 1'b1) begin
            nv_cnt++;
            nv_last = {nv_addr, nv_data};
        end
        rd_data <= rd_addr ^ 8'hA5;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic [7:0] v, input logic e);
        m.wbyte(v, ack);
        chk(16'(ack), 16'(e));
    endtask : wb
    task automatic wait_idle();
        for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++) @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask : wait_idle
    task automatic t_write_stop();
        int n0;
        n0 = nv_cnt;
        popped.delete();
        m.start();
        wb(8'h50, 1'b1);
        wb(8'h03, 1'b1);
        chk(16'(rd_addr), 16'h0003);
        wb(8'h5A, 1'b1);
        chk(popped.size() > 0 ? popped[0] : 16'hFFFF, 16'h035A);
        chk(16'(rd_addr), 16'h0004);
        m.stop();
        m.start();
        wb(8'h50, 1'b0);
        m.stop();
        chk(16'(nv_cnt - n0), 16'h0001);
        chk(nv_last, 16'h035A);
        wait_idle();
        m.start();
        wb(8'h50, 1'b1);
        m.stop();
    endtask : t_write_stop
    task automatic t_rstart_read();
        int n0;
        n0 = nv_cnt;
        m.start();
        wb(8'h50, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h33, 1'b1);
        m.start();
        wb(8'h51, 1'b1);
        m.rbyte(1'b0, b);
        chk(16'(b), 16'h00A4);
        m.rbyte(1'b1, b);
        chk(16'(b), 16'h00A7);
        m.stop();
        chk(16'(nv_cnt - n0), 16'h0000);
    endtask : t_rstart_read
    task automatic t_wiper();
        int n0;
        for (int w = 1; w >= 0; w--) begin
            wiper_only <= w[0];
            n0 = nv_cnt;
            m.start();
            wb(8'h50, 1'b1);
            wb(WIPER_LOC, 1'b1);
            wb(8'h77, 1'b1);
            m.stop();
            m.start();
            wb(8'h50, w[0]);
            m.stop();
            chk(16'(nv_cnt - n0), 16'(!w[0]));
            wait_idle();
        end
    endtask : t_wiper
    task automatic t_bad_addr();
        m.start();
        wb(8'h52, 1'b0);
        wb(8'h00, 1'b0);
        m.stop();
        m.start();
        wb(8'hA1, 1'b0);
        m.rbyte(1'b1, b);
        chk(16'(b), 16'h00FF);
        m.stop();
        chk(16'(rd_addr), 16'h0001);
    endtask : t_bad_addr
    task automatic t_fifo_full();
        wr_ready <= 1'b0;
        popped.delete();
        m.start();
        wb(8'h50, 1'b1);
        wb(8'h10, 1'b1);
        for (int i = 0; i < 17; i++) wb(8'(i), i < 16);
        m.stop();
        chk(16'(popped.size()), 16'h0000);
        chk(nv_last, 16'h1F0F);
        wr_ready <= 1'b1;
        for (int i = 0; i < 100 && wr_valid !== 1'b0; i++) @(posedge mclk);
        chk(16'(popped.size()), 16'h0010);
        for (int i = 0; i < 16; i++) chk(popped[i], {8'(8'h10 + i), 8'(i)});
        wait_idle();
    endtask : t_fifo_full
    task automatic stop_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        wiper_only = 1'b0;
        wr_ready = 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_write_stop();
        t_rstart_read();
        t_wiper();
        t_bad_addr();
        t_fifo_full();
        stop_test();
    end
endmodule : i2c_slave_nv_pot_port_test
